// file: pafs_mux.sv
// pin function multiplexer with APB selector registers
`timescale 1ns/10ps

module pafs_mux
    import pafs_pkg::*;
#(
    parameter int ADDR_WIDTH = 12
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // peripheral side
    input wire pafs_periph_s periph,
    output logic second_serial_receive,
    output logic second_spi_master_in,
    // general purpose i/o side
    input wire pafs_pin_s gpio,
    // pads
    input wire logic [PAFS_NUM_PINS-1:0] pin_in,
    output pafs_pin_s pin
);

    // address must hold the highest offset and fit one bus word
    if (ADDR_WIDTH < 4 || ADDR_WIDTH > 32) begin : g_bad_width
        $error("pafs_mux: ADDR_WIDTH out of range");
    end

    // drive of one pin under its selector: {oe, out}
    function automatic logic [1:0] route(input int n, input logic [2:0] c, input pafs_periph_s p,
                                         input logic go, input logic ge);
        logic [1:0] r;
        r = {ge, go};
        case (n)
            0: begin
                case (c)
                    PAFS_SEL_001: r = 2'h0;
                    PAFS_SEL_010: r = {1'b1, p.pulse_channel_six};
                    PAFS_SEL_011: r = {1'b1, p.test_conv_clock};
                    PAFS_SEL_110: r = {1'b1, p.quick_start_crystal_clock_b};
                    default: r = {ge, go};
                endcase
            end
            1: begin
                case (c)
                    PAFS_SEL_001: r = {1'b1, p.second_spi_master_out};
                    PAFS_SEL_010: r = {1'b1, p.pulse_channel_seven};
                    PAFS_SEL_011: r = {1'b1, p.test_conv_valid};
                    PAFS_SEL_100: r = {1'b1, p.link_layer_debug_bit7};
                    PAFS_SEL_110: r = {1'b1, p.quick_start_crystal_clock_a};
                    default: r = {ge, go};
                endcase
            end
            2: begin
                case (c)
                    PAFS_SEL_001: r = {1'b1, p.second_spi_clock};
                    PAFS_SEL_010: r = {1'b1, p.pulse_channel_zero};
                    PAFS_SEL_100: r = {1'b1, p.test_conv_data_low};
                    PAFS_SEL_110: r = {1'b1, p.first_spi_master_out};
                    default: r = {ge, go};
                endcase
            end
            3: begin
                case (c)
                    PAFS_SEL_001: r = {1'b1, p.second_spi_chip_select};
                    PAFS_SEL_010: r = {1'b1, p.pulse_channel_one};
                    PAFS_SEL_011: r = {1'b1, p.pll_clock_over_eight};
                    PAFS_SEL_100: r = {1'b1, p.test_conv_data_high};
                    // open drain: pull low only
                    PAFS_SEL_110: r = {~p.two_wire_clock_line, 1'b0};
                    default: r = {ge, go};
                endcase
            end
            4: begin
                case (c)
                    PAFS_SEL_001: r = 2'h0;
                    PAFS_SEL_010: r = 2'h0;
                    PAFS_SEL_011: r = {1'b1, p.pulse_channel_two};
                    PAFS_SEL_100: r = {1'b1, p.second_timer_count_output};
                    default: r = {ge, go};
                endcase
            end
            5: begin
                case (c)
                    PAFS_SEL_001: r = 2'h0;
                    PAFS_SEL_010: r = {1'b1, p.pulse_channel_six};
                    PAFS_SEL_011: r = 2'h0;
                    default: r = {ge, go};
                endcase
            end
            6: begin
                case (c)
                    PAFS_SEL_001: r = {1'b1, p.second_serial_transmit};
                    PAFS_SEL_010: r = {1'b1, p.pulse_channel_seven};
                    PAFS_SEL_011: r = {1'b1, p.second_spi_master_out};
                    default: r = {ge, go};
                endcase
            end
            default: r = {ge, go};
        endcase
        return r;
    endfunction

    // register state
    logic [31:0] port2_function_select;
    logic [31:0] port3_function_select;
    logic [31:0] next_port2;
    logic [31:0] next_port3;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic acc;
    logic hit2;
    logic hit3;

    assign acc = psel && penable && pready;
    assign hit2 = 32'(paddr) == 32'(PAFS_OFF_P2);
    assign hit3 = 32'(paddr) == 32'(PAFS_OFF_P3);

    // bus: one wait state, then answer
    always_comb begin
        next_port2 = port2_function_select;
        next_port3 = port3_function_select;
        next_pready = psel && penable && !pready;
        next_prdata = prdata;
        next_pslverr = 1'b0;
        if (psel && penable && !pready) begin
            next_pslverr = !(hit2 || hit3);
            next_prdata = 32'h0000_0000;
            if (!pwrite && hit2) begin
                next_prdata = port2_function_select;
            end
            if (!pwrite && hit3) begin
                next_prdata = port3_function_select;
            end
        end
        if (acc && pwrite && hit2) begin
            next_port2 = pwdata & PAFS_P2_MASK;
        end
        if (acc && pwrite && hit3) begin
            next_port3 = pwdata & PAFS_P3_MASK;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port2_function_select <= PAFS_P2_RESET;
            port3_function_select <= PAFS_P3_RESET;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            port2_function_select <= next_port2;
            port3_function_select <= next_port3;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // selectors and routing per pin
    logic [2:0] code [PAFS_NUM_PINS];
    pafs_pin_s next_pin;
    logic next_rx;
    logic next_miso;

    genvar g;
    generate
        for (g = 0; g < PAFS_NUM_PINS; g++) begin : g_pin
            if (g < PAFS_P2_PINS) begin : g_p2
                assign code[g] = pafs_code(port2_function_select, g);
            end else begin : g_p3
                assign code[g] = pafs_code(port3_function_select, g - PAFS_PIN_P3_0);
            end
            assign {next_pin.oe[g], next_pin.out[g]} = route(g, code[g], periph, gpio.out[g], gpio.oe[g]);
        end
    endgenerate

    // inputs back to peripherals, third port first
    always_comb begin
        next_rx = 1'b1;
        if (code[PAFS_PIN_P2_4] == PAFS_SEL_010) begin
            next_rx = pin_in[PAFS_PIN_P2_4];
        end
        if (code[PAFS_PIN_P3_0] == PAFS_SEL_001) begin
            next_rx = pin_in[PAFS_PIN_P3_0];
        end
        next_miso = 1'b0;
        if (code[PAFS_PIN_P2_0] == PAFS_SEL_001) begin
            next_miso = pin_in[PAFS_PIN_P2_0];
        end
        if (code[PAFS_PIN_P2_4] == PAFS_SEL_001) begin
            next_miso = pin_in[PAFS_PIN_P2_4];
        end
        if (code[PAFS_PIN_P3_0] == PAFS_SEL_011) begin
            next_miso = pin_in[PAFS_PIN_P3_0];
        end
    end

    // one register stage keeps pads free of decode glitches
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin <= '0;
            second_serial_receive <= 1'b1;
            second_spi_master_in <= 1'b0;
        end else begin
            pin <= next_pin;
            second_serial_receive <= next_rx;
            second_spi_master_in <= next_miso;
        end
    end

    // checks
    sequence s_wr3;
        psel && penable && pready && pwrite && hit3;
    endsequence

    sequence s_wr2;
        psel && penable && pready && pwrite && hit2;
    endsequence

    a_p3_ext_write: assert property (@(posedge pclk) disable iff (!presetn)
        s_wr3 |=> port3_function_select[23:16] == $past(pwdata[23:16]))
        else $error("third port extension bits not stored");

    a_p3_alt_reserved: assert property (@(posedge pclk) disable iff (!presetn)
        s_wr3 |=> port3_function_select[15:8] == $past(pwdata[15:8]) && port3_function_select[31:24] == 8'h00)
        else $error("third port alternate or reserved bits wrong");

    a_p3_low_reserved: assert property (@(posedge pclk) disable iff (!presetn)
        s_wr3 |=> port3_function_select[7:2] == 6'h00 && port3_function_select[1:0] == $past(pwdata[1:0]))
        else $error("third port reserved bits not zero");

    a_p3_pin1_tx: assert property (@(posedge pclk) disable iff (!presetn)
        code[PAFS_PIN_P3_1] == PAFS_SEL_001 |=> pin.oe[PAFS_PIN_P3_1]
            && pin.out[PAFS_PIN_P3_1] == $past(periph.second_serial_transmit))
        else $error("third port pin1 transmit not routed");

    a_p3_pin0_miso: assert property (@(posedge pclk) disable iff (!presetn)
        code[PAFS_PIN_P3_0] == PAFS_SEL_011 |=> !pin.oe[PAFS_PIN_P3_0]
            && second_spi_master_in == $past(pin_in[PAFS_PIN_P3_0]))
        else $error("third port pin0 master-in not routed");

    a_p2_pin3_scl: assert property (@(posedge pclk) disable iff (!presetn)
        code[3] == PAFS_SEL_110 |=> pin.out[3] == 1'b0 && pin.oe[3] == !$past(periph.two_wire_clock_line))
        else $error("second port pin3 clock line not open drain");

    a_p2_pin2_datl: assert property (@(posedge pclk) disable iff (!presetn)
        code[2] == PAFS_SEL_100 |=> pin.oe[2] && pin.out[2] == $past(periph.test_conv_data_low))
        else $error("second port pin2 data low not routed");

    a_p2_pin4_timer: assert property (@(posedge pclk) disable iff (!presetn)
        code[PAFS_PIN_P2_4] == PAFS_SEL_100 |=> pin.out[PAFS_PIN_P2_4] == $past(periph.second_timer_count_output))
        else $error("second port pin4 timer not routed");

    a_reserved_gpio: assert property (@(posedge pclk) disable iff (!presetn)
        code[PAFS_PIN_P3_1][2] |=> pin.out[PAFS_PIN_P3_1] == $past(gpio.out[PAFS_PIN_P3_1])
            && pin.oe[PAFS_PIN_P3_1] == $past(gpio.oe[PAFS_PIN_P3_1]))
        else $error("reserved code left the pin off gpio");

    a_switch_timing: assert property (@(posedge pclk) disable iff (!presetn)
        s_wr2 ##1 (code[0] == PAFS_SEL_010) |=> pin.oe[0] && pin.out[0] == $past(periph.pulse_channel_six))
        else $error("second port pin0 not switched one cycle after write");

    a_p2_fields_store: assert property (@(posedge pclk) disable iff (!presetn)
        s_wr2 |=> port2_function_select[23:0] == $past(pwdata[23:0]) && port2_function_select[31:24] == 8'h00)
        else $error("second port selector bits not stored");

    a_p2_pin1_debug: assert property (@(posedge pclk) disable iff (!presetn)
        code[1] == PAFS_SEL_100 |=> pin.oe[1] && pin.out[1] == $past(periph.link_layer_debug_bit7))
        else $error("second port pin1 debug bit not routed");

    a_p2_pin0_miso: assert property (@(posedge pclk) disable iff (!presetn)
        code[PAFS_PIN_P2_0] == PAFS_SEL_001 && code[PAFS_PIN_P2_4] != PAFS_SEL_001
            && code[PAFS_PIN_P3_0] != PAFS_SEL_011 |=> !pin.oe[PAFS_PIN_P2_0]
            && second_spi_master_in == $past(pin_in[PAFS_PIN_P2_0]))
        else $error("second port pin0 master-in not routed");

    a_p2_pin4_rx: assert property (@(posedge pclk) disable iff (!presetn)
        code[PAFS_PIN_P2_4] == PAFS_SEL_010 && code[PAFS_PIN_P3_0] != PAFS_SEL_001 |=> !pin.oe[PAFS_PIN_P2_4]
            && second_serial_receive == $past(pin_in[PAFS_PIN_P2_4]))
        else $error("second port pin4 receive not routed");

    a_p2_pin4_pwm: assert property (@(posedge pclk) disable iff (!presetn)
        code[PAFS_PIN_P2_4] == PAFS_SEL_011 |=> pin.oe[PAFS_PIN_P2_4]
            && pin.out[PAFS_PIN_P2_4] == $past(periph.pulse_channel_two))
        else $error("second port pin4 pulse channel two not routed");

endmodule

// file: pafs_pkg.sv
// constants, types and decoders shared by the pin function multiplexer
package pafs_pkg;

    // register byte offsets
    localparam logic [11:0] PAFS_OFF_P2 = 12'h008;
    localparam logic [11:0] PAFS_OFF_P3 = 12'h00c;

    // reset values and writable bits
    localparam logic [31:0] PAFS_P2_RESET = 32'h0000_0000;
    localparam logic [31:0] PAFS_P3_RESET = 32'h0000_0000;
    localparam logic [31:0] PAFS_P2_MASK = 32'h00ff_ffff;
    localparam logic [31:0] PAFS_P3_MASK = 32'h00ff_ff03;

    // field positions
    localparam int PAFS_EXT_LSB = 16;
    localparam int PAFS_ALT_LSB = 8;
    localparam int PAFS_PRI_LSB = 0;

    // routed pins: second port 0..4, third port 0..1
    localparam int PAFS_NUM_PINS = 7;
    localparam int PAFS_P2_PINS = 5;
    localparam int PAFS_PIN_P2_0 = 0;
    localparam int PAFS_PIN_P2_4 = 4;
    localparam int PAFS_PIN_P3_0 = 5;
    localparam int PAFS_PIN_P3_1 = 6;

    // selector codes as {extension, alternate, primary}
    localparam logic [2:0] PAFS_SEL_GPIO = 3'h0;
    localparam logic [2:0] PAFS_SEL_001 = 3'h1;
    localparam logic [2:0] PAFS_SEL_010 = 3'h2;
    localparam logic [2:0] PAFS_SEL_011 = 3'h3;
    localparam logic [2:0] PAFS_SEL_100 = 3'h4;
    localparam logic [2:0] PAFS_SEL_110 = 3'h6;

    // peripheral signals offered to the pins
    typedef struct packed {
        logic second_serial_transmit;
        logic pulse_channel_zero;
        logic pulse_channel_one;
        logic pulse_channel_two;
        logic pulse_channel_six;
        logic pulse_channel_seven;
        logic second_spi_chip_select;
        logic second_spi_clock;
        logic second_spi_master_out;
        logic first_spi_master_out;
        logic two_wire_clock_line;
        logic pll_clock_over_eight;
        logic test_conv_clock;
        logic test_conv_valid;
        logic test_conv_data_low;
        logic test_conv_data_high;
        logic link_layer_debug_bit7;
        logic quick_start_crystal_clock_a;
        logic quick_start_crystal_clock_b;
        logic second_timer_count_output;
    } pafs_periph_s;

    // pin drive, one bit per routed pin
    typedef struct packed {
        logic [PAFS_NUM_PINS-1:0] out;
        logic [PAFS_NUM_PINS-1:0] oe;
    } pafs_pin_s;

    // selector of port pin n out of its register
    function automatic logic [2:0] pafs_code(input logic [31:0] r, input int n);
        return {r[PAFS_EXT_LSB+n], r[PAFS_ALT_LSB+n], r[PAFS_PRI_LSB+n]};
    endfunction

endpackage

// file: pafs_far_side.sv
// far-side model: on-chip peripherals, gpio block and package pads
`timescale 1ns/10ps
module pafs_far_side
    import pafs_pkg::*;
(
    // bench control
    input wire logic [19:0] pick,
    input wire logic inv,
    input wire logic [PAFS_NUM_PINS-1:0] ext,
    // design side
    input wire pafs_pin_s pin,
    output pafs_periph_s periph,
    output pafs_pin_s gpio,
    output logic [PAFS_NUM_PINS-1:0] pin_in
);
    always_comb begin
        periph = pafs_periph_s'(pick ^ {20{inv}});
        gpio.out = {PAFS_NUM_PINS{inv}};
        gpio.oe = {PAFS_NUM_PINS{~inv}};
    end
    // pad level: design drive when enabled, else the outside world
    assign pin_in = (pin.oe & pin.out) | (~pin.oe & ext);
endmodule

// file: pafs_mux_bench.sv
// self-checking bench for the pin function multiplexer
`timescale 1ns/10ps
module pafs_mux_bench
    import pafs_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic rx;
    logic miso;
    logic [19:0] pick = 20'hf_ffff;
    logic inv = 1'b0;
    logic [6:0] ext = 7'h00;
    pafs_periph_s periph;
    pafs_pin_s gpio;
    pafs_pin_s pin_drv;
    logic [6:0] pin_in;
    logic [31:0] q;
    logic err;
    int mismatches = 0;
    int samples_checked = 0;
    int cycles = 0;
    // entries: pin, code, peripheral bit (ff gpio, fe receive, fd master-in, fc clock line)
    localparam logic [15:0] TBL [44] = '{
        16'h00ff, 16'h01fd, 16'h020f, 16'h0307, 16'h04ff, 16'h05ff, 16'h0601, 16'h07ff,
        16'h110b, 16'h120e, 16'h1306, 16'h1403, 16'h1602, 16'h17ff,
        16'h210c, 16'h2212, 16'h23ff, 16'h2405, 16'h260a, 16'h27ff,
        16'h310d, 16'h3211, 16'h3308, 16'h3404, 16'h36fc, 16'h37ff,
        16'h40ff, 16'h41fd, 16'h42fe, 16'h4310, 16'h4400, 16'h46ff, 16'h47ff,
        16'h50ff, 16'h51fe, 16'h520f, 16'h53fd, 16'h55ff, 16'h57ff,
        16'h6113, 16'h620e, 16'h630b, 16'h64ff, 16'h66ff
    };

    pafs_mux #(.ADDR_WIDTH(12)) i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .periph(periph), .second_serial_receive(rx), .second_spi_master_in(miso),
        .gpio(gpio), .pin_in(pin_in), .pin(pin_drv)
    );
    pafs_far_side i_far (
        .pick(pick), .inv(inv), .ext(ext), .pin(pin_drv), .periph(periph), .gpio(gpio), .pin_in(pin_in)
    );

    always #2 pclk = ~pclk;

    task automatic conclude();
        if (mismatches == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            conclude();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // program one selector, check routing in both signal polarities
    task automatic route(input logic [15:0] e);
        int p;
        int k;
        logic [7:0] b;
        logic [31:0] d;
        logic eo;
        p = int'(e[15:12]);
        b = e[7:0];
        k = (p < 5) ? p : p - 5;
        d = (32'(e[10]) << (16 + k)) | (32'(e[9]) << (8 + k)) | (32'(e[8]) << k);
        for (int ph = 0; ph < 2; ph++) begin
            pick <= (b < 8'h14) ? 20'h0_0001 << b : 20'hf_ffff;
            inv <= ph[0];
            ext <= (7'h01 << p) ^ {7{ph[0]}};
            if (ph == 0) begin
                apb(1'b1, (p < 5) ? 12'h008 : 12'h00c, d);
            end
            @(posedge pclk);
            #1;
            eo = (b == 8'hff) ? ~ph[0] : (b == 8'hfc) ? ph[0] : (b < 8'hfc);
            chk({31'h0, pin_drv.oe[p]}, {31'h0, eo});
            if (b < 8'hfc) chk({31'h0, pin_drv.out[p]}, {31'h0, ~ph[0]});
            if (b == 8'hff) chk({31'h0, pin_drv.out[p]}, {31'h0, ph[0]});
            if (b == 8'hfc) chk({31'h0, pin_drv.out[p]}, 32'h0000_0000);
            // pad loops back through the registered drive: one more cycle
            @(posedge pclk);
            #1;
            if (b == 8'hfe) chk({31'h0, rx}, {31'h0, ~ph[0]});
            if (b == 8'hfd) chk({31'h0, miso}, {31'h0, ~ph[0]});
            @(posedge pclk);
        end
    endtask

    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        chk({31'h0, rx}, 32'h0000_0001);
        chk({31'h0, miso}, 32'h0000_0000);
        apb(1'b1, 12'h010, 32'hffff_ffff);
        chk({31'h0, err}, 32'h0000_0001);
        apb(1'b0, 12'h010, 32'h0000_0000);
        chk({31'h0, err}, 32'h0000_0001);
        chk(q, 32'h0000_0000);
        apb(1'b0, 12'h008, 32'h0000_0000);
        chk(q, 32'h0000_0000);
        apb(1'b0, 12'h00c, 32'h0000_0000);
        chk(q, 32'h0000_0000);
        foreach (TBL[i]) route(TBL[i]);
        apb(1'b1, 12'h00c, 32'hffff_ffff);
        apb(1'b0, 12'h00c, 32'h0000_0000);
        chk(q, 32'h00ff_ff03);
        apb(1'b1, 12'h008, 32'hffff_ffff);
        apb(1'b0, 12'h008, 32'h0000_0000);
        chk(q, 32'h00ff_ffff);
        // second reset in mid-run must clear both selectors
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h00c, 32'h0000_0000);
        chk(q, 32'h0000_0000);
        apb(1'b0, 12'h008, 32'h0000_0000);
        chk(q, 32'h0000_0000);
        conclude();
    end
endmodule
